// >>> nvb_data_nvm.v
// data nonvolatile byte store reached through special function registers
`include "nvb_defines.vh"

// What this block does
// - array reached only through address, data, control
// - reads and writes allowed in normal running
// - every access is exactly one byte
// - one data byte register for both directions
// - 1024 bytes, linear address 000h to 3ffh
// - write erases location first, then programs
// - internal timer sets write duration
// - address is high two bits, low eight
// - high address upper six bits read zero
// - start bits only set by software, hardware clears
// - write refused unless permit bit set
// - core reset during write sets abort, zeroes registers
// - done flag set on write end, software clears
module nvb_data_nvm (
   ref_clk,
   rst_n,
   master_clear_reset,
   watchdog_timeout,
   reg_sel,
   reg_wr,
   reg_wdata,
   reg_rdata,
   nvm_done_flag,
   nvm_done_clr,
   nvm_busy
);
   input wire ref_clk;
   input wire rst_n;
   input wire master_clear_reset;
   input wire watchdog_timeout;
   input wire [2:0] reg_sel;
   input wire reg_wr;
   input wire [7:0] reg_wdata;
   output reg [7:0] reg_rdata;
   output reg nvm_done_flag;
   input wire nvm_done_clr;
   output wire nvm_busy;

   // sequencer states; erase and program are each a timed phase
   localparam ST_IDLE = 2'd0;
   localparam ST_READ = 2'd1;
   localparam ST_ERASE = 2'd2;
   localparam ST_PROG = 2'd3;

   // byte array, one entry per linear address; it has no reset, so a
   // byte never written since power-up holds no defined value
   reg [7:0] mem [0:`NVB_DEPTH-1];

   // sequencer state and write timer
   reg [1:0] state_r;
   reg [15:0] timer_r;

   // software-visible registers
   reg [7:0] nvm_data_byte_r;
   reg [1:0] nvm_addr_high_r; // only the two implemented bits
   reg [7:0] nvm_addr_low_r;

   // control bits
   reg rd_r;
   reg wr_r;
   reg permit_r;
   reg abort_r;

   // write operands frozen at the start edge, so software may reload
   // address and data while the array is still busy
   reg [`NVB_AW-1:0] wr_addr_r;
   reg [7:0] wr_byte_r;

   // decoded helpers and timer reload values
   wire [`NVB_AW-1:0] addr;
   wire sys_reset;
   wire ctrl_wr;
   wire [31:0] erase_load_w;
   wire [31:0] prog_load_w;

   // linear 10-bit address from both address registers
   assign addr = {nvm_addr_high_r, nvm_addr_low_r};

   // master clear and watchdog time-out act alike on this block
   assign sys_reset = master_clear_reset | watchdog_timeout;

   // strobe aimed at the control register
   assign ctrl_wr = reg_wr & (reg_sel == `NVB_SEL_CTRL);

   // busy covers the read cycle as well as both write phases
   assign nvm_busy = (state_r != ST_IDLE);

   // timer counts down to zero inclusive, so each load is one less than
   // its phase; a 16-bit timer caps a phase at 65536 cycles
   assign erase_load_w = `NVB_ERASE_CYC - 1;
   assign prog_load_w = `NVB_WRITE_CYC - `NVB_ERASE_CYC - 1;

   // register readback; unlock register is not physical and reads zero
   // reading has no side effect, so software may poll freely
   always @* begin
      reg_rdata = 8'h00;
      if (reg_sel == `NVB_SEL_CTRL) begin
         reg_rdata = {4'h0, abort_r, permit_r, wr_r, rd_r};
      end else if (reg_sel == `NVB_SEL_DATA) begin
         reg_rdata = nvm_data_byte_r;
      end else if (reg_sel == `NVB_SEL_ADDRH) begin
         reg_rdata = {6'h00, nvm_addr_high_r};
      end else if (reg_sel == `NVB_SEL_ADDRL) begin
         reg_rdata = nvm_addr_low_r;
      end
   end

   // array storage; erase leaves ff, program stores the latched byte
   // a core reset on the last program cycle leaves the byte erased,
   // never half programmed
   always @(posedge ref_clk) begin
      if (state_r == ST_ERASE && timer_r == 16'h0000) begin
         mem[wr_addr_r] <= 8'hff;
      end else if (state_r == ST_PROG && timer_r == 16'h0000 && !sys_reset) begin
         mem[wr_addr_r] <= wr_byte_r;
      end
   end

   // sequencer and software-visible registers
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // power-up: every register cleared, permit included
         state_r <= ST_IDLE;
         timer_r <= 16'h0000;
         nvm_data_byte_r <= `NVB_BYTE_RST;
         nvm_addr_high_r <= 2'h0;
         nvm_addr_low_r <= `NVB_BYTE_RST;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         permit_r <= 1'b0;
         abort_r <= 1'b0;
         wr_addr_r <= {`NVB_AW{1'b0}};
         wr_byte_r <= `NVB_BYTE_RST;
         nvm_done_flag <= 1'b0;
      end else if (sys_reset) begin
         // core reset: abort an unfinished write and clear operands
         if (state_r == ST_ERASE || state_r == ST_PROG) begin
            abort_r <= 1'b1;
            nvm_data_byte_r <= `NVB_BYTE_RST;
            nvm_addr_high_r <= 2'h0;
            nvm_addr_low_r <= `NVB_BYTE_RST;
         end
         // any core reset stops the sequencer and withdraws the permit
         state_r <= ST_IDLE;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         permit_r <= 1'b0;
      end else begin
         // software clear of done flag loses to a same-cycle set,
         // which is made further down at the end of the program phase
         if (nvm_done_clr) begin
            nvm_done_flag <= 1'b0;
         end

         // operand writes; a read result in the case below wins over
         // a data write in the same cycle
         if (reg_wr && reg_sel == `NVB_SEL_DATA) begin
            nvm_data_byte_r <= reg_wdata;
         end
         if (reg_wr && reg_sel == `NVB_SEL_ADDRH) begin
            nvm_addr_high_r <= reg_wdata[1:0];
         end
         if (reg_wr && reg_sel == `NVB_SEL_ADDRL) begin
            nvm_addr_low_r <= reg_wdata;
         end

         // permit and abort follow software; the start bits are taken
         // only by the sequencer, so a written zero cannot stop it
         if (ctrl_wr) begin
            permit_r <= reg_wdata[`NVB_CTRL_PERMIT];
            abort_r <= reg_wdata[`NVB_CTRL_ABORT];
         end

         case (state_r)
            ST_IDLE: begin
               // only a one may be written to the start bits; read wins
               // when both are set, and a write needs the permit already
               // set by an earlier control write, not by the same one
               if (ctrl_wr && reg_wdata[`NVB_CTRL_RD]) begin
                  rd_r <= 1'b1;
                  state_r <= ST_READ;
               end else if (ctrl_wr && reg_wdata[`NVB_CTRL_WR] && permit_r) begin
                  wr_r <= 1'b1;
                  wr_addr_r <= addr;
                  wr_byte_r <= nvm_data_byte_r;
                  timer_r <= erase_load_w[15:0];
                  state_r <= ST_ERASE;
               end
            end

            // single read cycle: data and the cleared rd bit appear together
            ST_READ: begin
               nvm_data_byte_r <= mem[addr];
               rd_r <= 1'b0;
               state_r <= ST_IDLE;
            end

            // erase phase; at zero the timer reloads for programming
            ST_ERASE: begin
               if (timer_r == 16'h0000) begin
                  timer_r <= prog_load_w[15:0];
                  state_r <= ST_PROG;
               end else begin
                  timer_r <= timer_r - 16'h0001;
               end
            end

            // program phase; its last cycle reports the write done
            default: begin
               if (timer_r == 16'h0000) begin
                  wr_r <= 1'b0;
                  nvm_done_flag <= 1'b1;
                  state_r <= ST_IDLE;
               end else begin
                  timer_r <= timer_r - 16'h0001;
               end
            end
         endcase
      end
   end
endmodule

// >>> nvb_defines.vh
// constants for the data nonvolatile byte access block
`ifndef NVB_DEFINES_VH
`define NVB_DEFINES_VH

// register select codes on the special function register port
`define NVB_SEL_CTRL 3'h0
`define NVB_SEL_UNLOCK 3'h1
`define NVB_SEL_DATA 3'h2
`define NVB_SEL_ADDRH 3'h3
`define NVB_SEL_ADDRL 3'h4

// control register bit positions
`define NVB_CTRL_RD 0
`define NVB_CTRL_WR 1
`define NVB_CTRL_PERMIT 2
`define NVB_CTRL_ABORT 3

// array geometry
`define NVB_DEPTH 1024
`define NVB_AW 10

// reset values
`define NVB_BYTE_RST 8'h00

// write time, in microseconds, and its cycle count at 100 MHz
`define NVB_WRITE_TIME_US 4
`define NVB_CLK_MHZ 100
`define NVB_WRITE_CYC (`NVB_WRITE_TIME_US * `NVB_CLK_MHZ)
`define NVB_ERASE_CYC (`NVB_WRITE_CYC / 2)

`endif

// >>> nvb_properties.sv
// port checks for the byte store
`include "nvb_defines.vh"
module nvb_props (
   input wire ref_clk,
   input wire rst_n,
   input wire master_clear_reset,
   input wire watchdog_timeout,
   input wire [2:0] reg_sel,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire nvm_done_flag,
   input wire nvm_done_clr,
   input wire nvm_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire core = master_clear_reset | watchdog_timeout;
   wire rd_go = reg_wr && reg_sel == `NVB_SEL_CTRL && reg_wdata[0] && !nvm_busy && !core;
   logic [15:0] cnt_r;
   // busy run length; only writes run long, so reads stay out
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         cnt_r <= 16'h0;
      else
         cnt_r <= nvm_busy ? cnt_r + 16'h1 : 16'h0;
   a_read_two_cycles: assert property (
      rd_go |=> nvm_busy ##1 !nvm_busy) else $error("read length");
   a_write_time_fixed: assert property (
      $rose(nvm_done_flag) |-> cnt_r == `NVB_WRITE_CYC) else $error("write length");
   a_write_runs_on: assert property (
      nvm_busy && cnt_r > 16'h2 && cnt_r < 16'h12c && !core |=> nvm_busy) else $error("cut");
   a_done_holds: assert property (
      nvm_done_flag && !nvm_done_clr |=> nvm_done_flag) else $error("done lost");
   a_done_clears: assert property (
      nvm_done_clr && !nvm_busy |=> !nvm_done_flag) else $error("done stuck");
   a_high_upper_zero: assert property (
      reg_sel == `NVB_SEL_ADDRH |-> reg_rdata[7:2] == 6'h0) else $error("addr high");
   a_unlock_reads_zero: assert property (
      reg_sel == `NVB_SEL_UNLOCK |-> reg_rdata == 8'h00) else $error("unlock read");
   a_core_reset_idle: assert property (
      core |=> !nvm_busy) else $error("busy after reset");
endmodule

// >>> nvb_tb.sv
// self-checking bench for the byte store
`include "nvb_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst_n = 1'b0, master_clear_reset = 1'b0, watchdog_timeout = 1'b0;
   logic reg_wr = 1'b0, nvm_done_clr = 1'b0;
   logic [2:0] reg_sel = 3'h0;
   logic [7:0] reg_wdata = 8'h00, v;
   wire [7:0] reg_rdata;
   wire nvm_done_flag, nvm_busy;
   int num_errors = 0, cmp_count = 0;
   nvb_data_nvm dut_u (.ref_clk, .rst_n, .master_clear_reset, .watchdog_timeout, .reg_sel,
      .reg_wr, .reg_wdata, .reg_rdata, .nvm_done_flag, .nvm_done_clr, .nvm_busy);
   always #5 ref_clk = ~ref_clk;
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   // one-cycle strobe, dropped on the edge that takes it
   task automatic put(logic [2:0] s, logic [7:0] d);
      @(posedge ref_clk);
      reg_sel <= s;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic get(logic [2:0] s);
      @(posedge ref_clk);
      reg_sel <= s;
      #1 v = reg_rdata;
   endtask
   // waits out the sequencer off the edge; an overrun counts as a mismatch
   task automatic settle;
      #1;
      for (int i = 0; i < 1000 && nvm_busy !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("idle", {7'h0, nvm_busy}, 8'h00);
   endtask
   task automatic access(logic [9:0] a, logic [7:0] d, logic [7:0] c);
      put(`NVB_SEL_ADDRH, {6'h0, a[9:8]});
      put(`NVB_SEL_ADDRL, a[7:0]);
      put(`NVB_SEL_DATA, d);
      put(`NVB_SEL_CTRL, 8'h04);
      put(`NVB_SEL_CTRL, c);
   endtask
   task automatic t_regs;
      put(`NVB_SEL_ADDRH, 8'hff);
      get(`NVB_SEL_ADDRH);
      chk("addrh", v, 8'h03);
      get(`NVB_SEL_UNLOCK);
      chk("unlock", v, 8'h00);
      get(`NVB_SEL_CTRL);
      chk("ctrl", v, 8'h00);
      put(`NVB_SEL_CTRL, 8'h02);
      #1 chk("busy", {7'h0, nvm_busy}, 8'h00);
      $display("regs test done");
   endtask
   // rewrite of 0ff checks erase; 3ff catches a dropped high bit
   task automatic t_rw;
      access(10'h0ff, 8'h5a, 8'h06);
      settle;
      chk("done", {7'h0, nvm_done_flag}, 8'h01);
      get(`NVB_SEL_CTRL);
      chk("ctrl", v, 8'h04);
      @(posedge ref_clk);
      nvm_done_clr <= 1'b1;
      @(posedge ref_clk);
      nvm_done_clr <= 1'b0;
      #1 chk("done", {7'h0, nvm_done_flag}, 8'h00);
      access(10'h3ff, 8'ha5, 8'h06);
      settle;
      access(10'h0ff, 8'h3c, 8'h06);
      settle;
      for (int i = 0; i < 2; i++) begin
         access(i ? 10'h3ff : 10'h0ff, 8'h00, 8'h01);
         settle;
         get(`NVB_SEL_DATA);
         chk("data", v, i ? 8'ha5 : 8'h3c);
      end
      $display("rw test done");
   endtask
   task automatic t_abort;
      for (int i = 0; i < 2; i++) begin
         access(10'h155, 8'h77, 8'h06);
         repeat (50) @(posedge ref_clk);
         put(`NVB_SEL_CTRL, 8'h04);
         #1 chk("busy", {7'h0, nvm_busy}, 8'h01);
         // core reset raised and dropped on rising edges, one cycle long
         @(posedge ref_clk);
         master_clear_reset <= (i == 0);
         watchdog_timeout <= (i == 1);
         @(posedge ref_clk);
         master_clear_reset <= 1'b0;
         watchdog_timeout <= 1'b0;
         get(`NVB_SEL_CTRL);
         chk("ctrl", v, 8'h08);
         get(`NVB_SEL_DATA);
         chk("data", v, 8'h00);
         get(`NVB_SEL_ADDRL);
         chk("addrl", v, 8'h00);
         get(`NVB_SEL_ADDRH);
         chk("addrh", v, 8'h00);
         put(`NVB_SEL_CTRL, 8'h00);
      end
      $display("abort test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs;
      t_rw;
      t_abort;
      give_verdict;
   end
   // about seven times the expected run of some 1500 cycles
   initial begin
      #100us;
      num_errors++;
      give_verdict;
   end
endmodule
bind nvb_data_nvm nvb_props chk_u (.ref_clk, .rst_n, .master_clear_reset, .watchdog_timeout,
   .reg_sel, .reg_wr, .reg_wdata, .reg_rdata, .nvm_done_flag, .nvm_done_clr, .nvm_busy);
